// ===== bench/diag_status_regs_sva.sv
// Purpose: port-level checker for the diagnostic register slice
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   thresholds are shadowed from writes seen at the port
`timescale 1ns/1ps
module diag_status_regs_sva
    import diag_pkg::*;
(
    // clock and reset
    input wire logic                      i_ref_clk,
    input wire logic                      i_nrst,
    // register port
    input wire logic [7:0]                i_reg_addr,
    input wire logic                      i_reg_wr,
    input wire logic [7:0]                i_reg_wdata,
    input wire logic                      i_reg_rd,
    input wire logic [7:0]                o_reg_rdata,
    input wire logic                      o_reg_rvalid,
    // analog side and configuration
    input wire raw_event_t                i_raw_events,
    input wire logic [MONITOR_CODE_W-1:0] i_monitor_code,
    input wire logic                      i_monitor_valid,
    input wire diag_ctrl_t                o_ctrl,
    input wire logic [MONITOR_CODE_W-1:0] o_monitor_data,
    input wire logic                      o_upper_thresh_fault,
    input wire logic                      o_lower_thresh_fault
);
    // ==========================================================
    // shadow state
    logic [7:0] up, lo, next_up, next_lo;
    logic [2:0] stab, next_stab;
    raw_event_t prev;
    logic       steady;
    logic       rd41, rd42, rd43;

    // live bits are only judged once the inputs sat still past the sync chain
    always_comb
    begin
        next_up   = (i_reg_wr && i_reg_addr == ADDR_MONITOR_UPPER_THRESH) ? i_reg_wdata : up;
        next_lo   = (i_reg_wr && i_reg_addr == ADDR_MONITOR_LOWER_THRESH) ? i_reg_wdata : lo;
        next_stab = (i_raw_events != prev) ? 3'h0 : (stab == 3'h4) ? stab : stab + 3'h1;
        steady    = (stab == 3'h4) && (i_raw_events == prev) && i_reg_rd;
        rd41      = steady && i_reg_addr == ADDR_OUTPUT_CH2_FAULT;
        rd42      = steady && i_reg_addr == ADDR_HEADSET_EVENT_LIVE;
        rd43      = steady && i_reg_addr == ADDR_THRESH_VOICE_LIVE;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            {up, lo, stab, prev} <= {RST_UPPER_THRESH, RST_LOWER_THRESH, 3'h0, 10'h0};
        else
            {up, lo, stab, prev} <= {next_up, next_lo, next_stab, i_raw_events};
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    // ==========================================================
    // properties
    a_read_answer: assert property (o_reg_rvalid == $past(i_reg_rd))
        else $error("read strobe not answered by one rvalid pulse");
    a_upper_compare: assert property (i_monitor_valid |=>
        o_upper_thresh_fault == ($past(i_monitor_code) > {$past(up), 4'h0}))
        else $error("upper fault differs from compare");
    a_lower_compare: assert property (i_monitor_valid |=>
        o_lower_thresh_fault == ($past(i_monitor_code) < {$past(lo), 4'h0}))
        else $error("lower fault differs from compare");
    a_fault_hold: assert property (!i_monitor_valid |=> $stable(o_upper_thresh_fault)
        && $stable(o_lower_thresh_fault))
        else $error("fault moved without a sample");
    a_diag_write: assert property (i_reg_wr && i_reg_addr == ADDR_DIAG_DATA_CONTROL
        |=> o_ctrl[3:0] == $past(i_reg_wdata[3:0]))
        else $error("control bits not taken from write");
    a_filter_write: assert property (i_reg_wr && i_reg_addr == ADDR_SUPPLY_FILTER_SELECT
        |=> o_ctrl[7:4] == {$past(i_reg_wdata[6:5]), $past(i_reg_wdata[3:2])})
        else $error("filter selects not taken from write");
    a_monitor_hold: assert property (i_monitor_valid && o_ctrl.monitor_data_freeze
        |=> $stable(o_monitor_data))
        else $error("frozen monitor data changed");
    a_monitor_follow: assert property (i_monitor_valid && !o_ctrl.monitor_data_freeze
        |=> o_monitor_data == $past(i_monitor_code))
        else $error("monitor data not updated");
    a_ch2_live: assert property (rd41 |=> o_reg_rdata == {prev[9:6], 3'h0, prev[5]})
        else $error("channel 2 live status wrong");
    a_headset_live: assert property (rd42 |=> o_reg_rdata == {4'h0, prev[4:2], 1'b0})
        else $error("headset live status wrong");
    a_voice_live: assert property (rd43 |=> o_reg_rdata[5:4] == prev[1:0])
        else $error("voice live status wrong");

    c_read: cover property (i_reg_rd ##1 o_reg_rvalid);
    c_upper: cover property (o_upper_thresh_fault && o_lower_thresh_fault == 1'b0);
    c_freeze: cover property (i_monitor_valid && o_ctrl.monitor_data_freeze);
endmodule

bind diag_status_regs diag_status_regs_sva u_diag_status_regs_sva (.i_ref_clk, .i_nrst,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_raw_events,
    .i_monitor_code, .i_monitor_valid, .o_ctrl, .o_monitor_data, .o_upper_thresh_fault,
    .o_lower_thresh_fault);

// ===== bench/tb.sv
// Purpose: self-checking bench for the diagnostic register slice
// Assumes: inputs driven by non-blocking assignment at rising edges
// Notes:   live inputs are held still while they are read back
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb
    import diag_pkg::*;
;
    // ==========================================================
    // stimulus, outputs and model
    logic                      i_ref_clk = 1'b0;
    logic                      i_nrst = 1'b0;
    logic [7:0]                i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
    logic                      i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_monitor_valid = 1'b0;
    raw_event_t                i_raw_events = '0;
    logic [MONITOR_CODE_W-1:0] i_monitor_code = '0, o_monitor_data, m_md;
    logic                      o_reg_rvalid, o_upper_thresh_fault, o_lower_thresh_fault;
    diag_ctrl_t                o_ctrl;
    int                        num_errors = 0, checks = 0;
    logic [31:0]               seed = 32'h1;
    logic [7:0]                m_up, m_lo, m_flt, m_dd, m_l1, m_l2;
    logic                      m_uf, m_lf;
    logic [7:0] atab [10] = '{8'h3a, 8'h3b, 8'h41, 8'h42, 8'h43, 8'h4e, 8'h4f, 8'h54, 8'h55, 8'h60};

    initial forever #20 i_ref_clk = ~i_ref_clk;

    diag_status_regs u_diag_status_regs (.i_ref_clk, .i_nrst, .i_reg_addr, .i_reg_wr,
        .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_raw_events, .i_monitor_code,
        .i_monitor_valid, .o_ctrl, .o_monitor_data, .o_upper_thresh_fault, .o_lower_thresh_fault);

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        raw_event_t r;
        r = i_raw_events;
        case (a)
            8'h41: return {r.ch2_positive_output_short, r.ch2_negative_output_short,
                r.driver_positive_side_vgnd, r.driver_negative_side_vgnd, 3'h0, r.regulator_short_live};
            8'h42: return {4'h0, r.headset_insert, r.headset_remove, r.headset_hook, 1'b0};
            8'h43: return {m_uf, m_lf, r.voice_power_up, r.voice_power_down, 4'h0};
            8'h3a: return m_l1;
            8'h3b: return m_l2;
            8'h4e: return m_up;
            8'h4f: return m_lo;
            8'h54: return m_flt;
            8'h55: return m_dd;
            default: return 8'h00;
        endcase
    endfunction

    // ==========================================================
    // port tasks
    task automatic do_reset();
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        {m_up, m_lo, m_flt, m_dd} = {8'hba, 8'h4b, 8'h48, 8'h00};
        {m_l1, m_l2, m_uf, m_lf, m_md} = '0;
        repeat (6) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
        case (a)
            8'h4e: m_up = d;
            8'h4f: m_lo = d;
            8'h54: m_flt = d & 8'h7f;
            8'h55: m_dd = d;
            default: ;
        endcase
        @(negedge i_ref_clk);
        `CHK("ctrl", {m_flt[6:5], m_flt[3:2], m_dd[3:0]}, o_ctrl)
    endtask

    // a latch read hands back the old value, then keeps only what is still live
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = exp_rd(a);
        @(posedge i_ref_clk);
        {i_reg_addr, i_reg_rd} <= {a, 1'b1};
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        @(negedge i_ref_clk);
        `CHK("rvalid", 1'b1, o_reg_rvalid)
        `CHK("rdata", e, o_reg_rdata)
        if (a == 8'h3a) m_l1 = exp_rd(8'h42);
        if (a == 8'h3b) m_l2 = exp_rd(8'h43);
    endtask

    task automatic mon(input logic [11:0] c);
        @(posedge i_ref_clk);
        {i_monitor_code, i_monitor_valid} <= {c, 1'b1};
        @(posedge i_ref_clk);
        i_monitor_valid <= 1'b0;
        m_uf = c > {m_up, 4'h0};
        m_lf = c < {m_lo, 4'h0};
        if (!m_dd[0]) m_md = c;
        m_l2 |= exp_rd(8'h43);
        @(negedge i_ref_clk);
        `CHK("upper", m_uf, o_upper_thresh_fault)
        `CHK("lower", m_lf, o_lower_thresh_fault)
        `CHK("mdata", m_md, o_monitor_data)
    endtask

    task automatic set_raw(input raw_event_t v);
        @(posedge i_ref_clk);
        i_raw_events <= v;
        repeat (6) @(posedge i_ref_clk);
        m_l1 |= exp_rd(8'h42);
        m_l2 |= exp_rd(8'h43);
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial
    begin
        logic [31:0] r;
        logic [7:0]  a;
        do_reset();
        foreach (atab[i]) rd(atab[i]);
        for (int i = 0; i < RAW_EVENT_W; i++)
        begin
            set_raw(raw_event_t'(10'h1 << i));
            rd(8'h41);
            rd(8'h42);
            rd(8'h43);
            set_raw('0);
            rd(8'h3a);
            rd(8'h3b);
            rd(8'h41);
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h54, {1'b0, 2'(c), 1'b0, 2'(c), 2'h0});
            wr(8'h55, 8'h1 << c);
            rd(8'h54);
        end
        wr(8'h55, 8'h00);
        wr(8'h4e, 8'h80);
        wr(8'h4f, 8'h20);
        mon(12'h800);
        mon(12'h801);
        rd(8'h43);
        mon(12'h200);
        mon(12'h1ff);
        rd(8'h43);
        wr(8'h55, 8'h01);
        mon(12'h555);
        rd(8'h3b);
        for (int n = 0; n < 300; n++)
        begin
            r = xs();
            a = atab[r[7:4] % 10];
            case (r[1:0])
                2'h0: wr(a, (a == 8'h54) ? r[15:8] & 8'h6c : (a == 8'h55) ? r[15:8] & 8'h0f : r[15:8]);
                2'h1: rd(a);
                2'h2: mon(r[27:16]);
                default: set_raw(raw_event_t'(r[25:16]));
            endcase
        end
        set_raw('0);
        do_reset();
        foreach (atab[i]) rd(atab[i]);
        report_and_stop();
    end

    // the directed and random parts need about 1350 cycles
    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        num_errors++;
        report_and_stop();
    end
endmodule

// ===== core/diag_pkg.sv
// Purpose: shared constants and carrier types of the codec diagnostic
//          status and configuration register slice
// Assumes: 8-bit registers at byte addresses on the device control port
// Notes:   offsets, field positions and reset values live here only
package diag_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_HEADSET_EVENT_LATCH  = 8'h3a;
    localparam logic [7:0] ADDR_THRESH_EVENT_LATCH   = 8'h3b;
    localparam logic [7:0] ADDR_OUTPUT_CH2_FAULT     = 8'h41;
    localparam logic [7:0] ADDR_HEADSET_EVENT_LIVE   = 8'h42;
    localparam logic [7:0] ADDR_THRESH_VOICE_LIVE    = 8'h43;
    localparam logic [7:0] ADDR_MONITOR_UPPER_THRESH = 8'h4e;
    localparam logic [7:0] ADDR_MONITOR_LOWER_THRESH = 8'h4f;
    localparam logic [7:0] ADDR_SUPPLY_FILTER_SELECT = 8'h54;
    localparam logic [7:0] ADDR_DIAG_DATA_CONTROL    = 8'h55;

    // ==========================================================
    // reset values
    localparam logic [7:0] RST_STATUS                = 8'h00;
    localparam logic [7:0] RST_UPPER_THRESH          = 8'hba;
    localparam logic [7:0] RST_LOWER_THRESH          = 8'h4b;
    localparam logic [7:0] RST_SUPPLY_FILTER_SELECT  = 8'h48;
    localparam logic [7:0] RST_DIAG_DATA_CONTROL     = 8'h00;
    localparam logic [7:0] RST_UNMAPPED_READ         = 8'h00;

    // ==========================================================
    // field positions: output channel 2 fault status
    localparam int unsigned BIT_CH2_POS_SHORT        = 7;
    localparam int unsigned BIT_CH2_NEG_SHORT        = 6;
    localparam int unsigned BIT_CH2_DRV_POS_VGND     = 5;
    localparam int unsigned BIT_CH2_DRV_NEG_VGND     = 4;
    localparam int unsigned BIT_REGULATOR_SHORT      = 0;
    // headset events
    localparam int unsigned BIT_HEADSET_INSERT       = 3;
    localparam int unsigned BIT_HEADSET_REMOVE       = 2;
    localparam int unsigned BIT_HEADSET_HOOK         = 1;
    // threshold and voice activity events
    localparam int unsigned BIT_UPPER_THRESH_FAULT   = 7;
    localparam int unsigned BIT_LOWER_THRESH_FAULT   = 6;
    localparam int unsigned BIT_VOICE_POWER_UP       = 5;
    localparam int unsigned BIT_VOICE_POWER_DOWN     = 4;
    // supply filter select
    localparam int unsigned POS_SUPPLY_FILT_LSB      = 5;
    localparam int unsigned POS_BATTERY_FILT_LSB     = 2;
    localparam logic [7:0]  MASK_SUPPLY_FILTER_WR    = 8'h7f;
    // diag data control
    localparam int unsigned BIT_CURRENT_ROUTING      = 3;
    localparam int unsigned BIT_CURRENT_FREEZE       = 2;
    localparam int unsigned BIT_BATT_TEMP_OVERRIDE   = 1;
    localparam int unsigned BIT_MONITOR_FREEZE       = 0;

    // ==========================================================
    // monitor code scaling: an 8-bit threshold N stands for code N*16
    localparam int unsigned MONITOR_CODE_W           = 12;
    localparam int unsigned THRESH_SCALE_SHIFT       = 4;
    localparam int unsigned SYNC_STAGES              = 2;
    localparam int unsigned RAW_EVENT_W              = 10;

    // filter settings, shared by the supply and battery selects
    typedef enum logic [1:0] {
        FILT_3M5HZ  = 2'h0,
        FILT_200KHZ = 2'h1,
        FILT_100KHZ = 2'h2,
        FILT_NONE   = 2'h3
    } filter_sel_t;

    // raw conditions from the analog side, asynchronous to the clock
    typedef struct packed {
        logic ch2_positive_output_short;
        logic ch2_negative_output_short;
        logic driver_positive_side_vgnd;
        logic driver_negative_side_vgnd;
        logic regulator_short_live;
        logic headset_insert;
        logic headset_remove;
        logic headset_hook;
        logic voice_power_up;
        logic voice_power_down;
    } raw_event_t;

    // configuration handed to the analog and converter logic
    typedef struct packed {
        filter_sel_t analog_supply_filter_sel;
        filter_sel_t battery_filter_sel;
        logic        current_data_routing_en;
        logic        current_data_freeze;
        logic        battery_temp_override;
        logic        monitor_data_freeze;
    } diag_ctrl_t;

endpackage

// ===== core/diag_status_regs.sv
// Purpose: diagnostic live status, latched event copies, monitor
//          thresholds, filter selects and readback data controls
// Assumes: control port front end delivers decoded byte accesses on
//          i_ref_clk; analog conditions arrive asynchronously
// Notes:   read data is registered, one cycle after the read strobe
//
// Function
// - ch2 output shorts in bits 7, 6
// - ch2 driver virtual-ground faults in bits 5, 4
// - regulator live short fault in bit 0
// - headset insert, remove, hook in bits 3-1
// - upper, lower threshold faults in bits 7, 6
// - voice power up, down in bits 5, 4
// - upper threshold register, reset 0xba
// - lower threshold register, reset 0x4b
// - supply filter select bits 6-5, reset 10b
// - battery filter select bits 3-2, reset 10b
// - bit 3 routes current data to diag
// - bit 2 freezes current-sense data
// - bit 1 enables battery/temperature override
// - bit 0 freezes monitor converter data
// - latched event copies clear on read
`timescale 1ns/1ps
module diag_status_regs
    import diag_pkg::*;
(
    // clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_nrst,
    // register access from the control port
    input  wire logic [7:0]                i_reg_addr,
    input  wire logic                      i_reg_wr,
    input  wire logic [7:0]                i_reg_wdata,
    input  wire logic                      i_reg_rd,
    output logic      [7:0]                o_reg_rdata,
    output logic                           o_reg_rvalid,
    // analog conditions
    input  wire raw_event_t                i_raw_events,
    // monitor converter samples, same clock
    input  wire logic [MONITOR_CODE_W-1:0] i_monitor_code,
    input  wire logic                      i_monitor_valid,
    // configuration and held monitor data
    output diag_ctrl_t                     o_ctrl,
    output logic      [MONITOR_CODE_W-1:0] o_monitor_data,
    output logic                           o_upper_thresh_fault,
    output logic                           o_lower_thresh_fault
);

    // ==========================================================
    // synchronised live conditions
    raw_event_t                live;
    logic [RAW_EVENT_W-1:0]    live_bits;

    diag_sync #(
        .WIDTH (RAW_EVENT_W)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_nrst    (i_nrst),
        .i_async   (i_raw_events),
        .o_sync    (live_bits)
    );

    assign live = raw_event_t'(live_bits);

    // ==========================================================
    // state
    logic [7:0]                upper_thresh;
    logic [7:0]                lower_thresh;
    logic [7:0]                supply_filter;
    logic [7:0]                data_control;
    logic                      upper_fault;
    logic                      lower_fault;
    logic [7:0]                headset_latch;
    logic [7:0]                thresh_latch;
    logic [MONITOR_CODE_W-1:0] monitor_data;
    logic [7:0]                rdata;
    logic                      rvalid;

    logic [7:0]                next_upper_thresh;
    logic [7:0]                next_lower_thresh;
    logic [7:0]                next_supply_filter;
    logic [7:0]                next_data_control;
    logic                      next_upper_fault;
    logic                      next_lower_fault;
    logic [7:0]                next_headset_latch;
    logic [7:0]                next_thresh_latch;
    logic [MONITOR_CODE_W-1:0] next_monitor_data;
    logic [7:0]                next_rdata;
    logic                      next_rvalid;

    // live register images, assembled from current conditions
    logic [7:0]                ch2_status;
    logic [7:0]                headset_live;
    logic [7:0]                thresh_live;
    logic [MONITOR_CODE_W-1:0] upper_code;
    logic [MONITOR_CODE_W-1:0] lower_code;

    // ==========================================================
    // live status images
    always_comb
    begin
        ch2_status                          = RST_STATUS;
        ch2_status[BIT_CH2_POS_SHORT]       = live.ch2_positive_output_short;
        ch2_status[BIT_CH2_NEG_SHORT]       = live.ch2_negative_output_short;
        ch2_status[BIT_CH2_DRV_POS_VGND]    = live.driver_positive_side_vgnd;
        ch2_status[BIT_CH2_DRV_NEG_VGND]    = live.driver_negative_side_vgnd;
        ch2_status[BIT_REGULATOR_SHORT]     = live.regulator_short_live;

        headset_live                        = RST_STATUS;
        headset_live[BIT_HEADSET_INSERT]    = live.headset_insert;
        headset_live[BIT_HEADSET_REMOVE]    = live.headset_remove;
        headset_live[BIT_HEADSET_HOOK]      = live.headset_hook;

        thresh_live                         = RST_STATUS;
        thresh_live[BIT_UPPER_THRESH_FAULT] = upper_fault;
        thresh_live[BIT_LOWER_THRESH_FAULT] = lower_fault;
        thresh_live[BIT_VOICE_POWER_UP]     = live.voice_power_up;
        thresh_live[BIT_VOICE_POWER_DOWN]   = live.voice_power_down;
    end

    // ==========================================================
    // threshold compare on the monitor code
    // thresholds cover the top eight bits of the code; the low nibble
    // is zero, so the compare resolution is sixteen codes
    always_comb
    begin
        upper_code = {upper_thresh, {THRESH_SCALE_SHIFT{1'b0}}};
        lower_code = {lower_thresh, {THRESH_SCALE_SHIFT{1'b0}}};
        next_upper_fault = upper_fault;
        next_lower_fault = lower_fault;
        if (i_monitor_valid)
        begin
            // each fault follows the latest sample in both directions
            next_upper_fault = (i_monitor_code > upper_code);
            next_lower_fault = (i_monitor_code < lower_code);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            upper_fault <= 1'b0;
            lower_fault <= 1'b0;
        end
        else
        begin
            upper_fault <= next_upper_fault;
            lower_fault <= next_lower_fault;
        end
    end

    // ==========================================================
    // held monitor data
    // samples keep flowing into the compare while the held copy is
    // frozen, so a fault is never missed during a long readback
    always_comb
    begin
        next_monitor_data = monitor_data;
        if (i_monitor_valid && !data_control[BIT_MONITOR_FREEZE])
            next_monitor_data = i_monitor_code;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            monitor_data <= '0;
        else
            monitor_data <= next_monitor_data;
    end

    // ==========================================================
    // configuration registers
    always_comb
    begin
        next_upper_thresh  = upper_thresh;
        next_lower_thresh  = lower_thresh;
        next_supply_filter = supply_filter;
        next_data_control  = data_control;
        if (i_reg_wr)
        begin
            // writes to the status addresses fall through: read-only
            case (i_reg_addr)
                ADDR_MONITOR_UPPER_THRESH: next_upper_thresh = i_reg_wdata;
                ADDR_MONITOR_LOWER_THRESH: next_lower_thresh = i_reg_wdata;
                // bit 7 is read-only zero; reserved writable bits are kept
                // as written, software is expected to write them as reset
                ADDR_SUPPLY_FILTER_SELECT:
                    next_supply_filter = i_reg_wdata & MASK_SUPPLY_FILTER_WR;
                ADDR_DIAG_DATA_CONTROL:    next_data_control = i_reg_wdata;
                default:                   next_upper_thresh = upper_thresh;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            upper_thresh  <= RST_UPPER_THRESH;
            lower_thresh  <= RST_LOWER_THRESH;
            supply_filter <= RST_SUPPLY_FILTER_SELECT;
            data_control  <= RST_DIAG_DATA_CONTROL;
        end
        else
        begin
            upper_thresh  <= next_upper_thresh;
            lower_thresh  <= next_lower_thresh;
            supply_filter <= next_supply_filter;
            data_control  <= next_data_control;
        end
    end

    // ==========================================================
    // latched event copies
    // a read clears the copy, but a condition still present in the
    // same cycle sets it again: the set always wins over the clear
    always_comb
    begin
        next_headset_latch = headset_latch;
        next_thresh_latch  = thresh_latch;
        if (i_reg_rd && (i_reg_addr == ADDR_HEADSET_EVENT_LATCH))
            next_headset_latch = RST_STATUS;
        if (i_reg_rd && (i_reg_addr == ADDR_THRESH_EVENT_LATCH))
            next_thresh_latch = RST_STATUS;
        next_headset_latch = next_headset_latch | headset_live;
        next_thresh_latch  = next_thresh_latch | thresh_live;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            headset_latch <= RST_STATUS;
            thresh_latch  <= RST_STATUS;
        end
        else
        begin
            headset_latch <= next_headset_latch;
            thresh_latch  <= next_thresh_latch;
        end
    end

    // ==========================================================
    // read path
    always_comb
    begin
        next_rvalid = i_reg_rd;
        next_rdata  = rdata;
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                ADDR_HEADSET_EVENT_LATCH:  next_rdata = headset_latch;
                ADDR_THRESH_EVENT_LATCH:   next_rdata = thresh_latch;
                ADDR_OUTPUT_CH2_FAULT:     next_rdata = ch2_status;
                ADDR_HEADSET_EVENT_LIVE:   next_rdata = headset_live;
                ADDR_THRESH_VOICE_LIVE:    next_rdata = thresh_live;
                ADDR_MONITOR_UPPER_THRESH: next_rdata = upper_thresh;
                ADDR_MONITOR_LOWER_THRESH: next_rdata = lower_thresh;
                ADDR_SUPPLY_FILTER_SELECT: next_rdata = supply_filter;
                ADDR_DIAG_DATA_CONTROL:    next_rdata = data_control;
                default:                   next_rdata = RST_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata  <= RST_STATUS;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign o_reg_rdata          = rdata;
    assign o_reg_rvalid         = rvalid;
    assign o_monitor_data       = monitor_data;
    assign o_upper_thresh_fault = upper_fault;
    assign o_lower_thresh_fault = lower_fault;

    always_comb
    begin
        o_ctrl.analog_supply_filter_sel =
            filter_sel_t'(supply_filter[POS_SUPPLY_FILT_LSB +: 2]);
        o_ctrl.battery_filter_sel =
            filter_sel_t'(supply_filter[POS_BATTERY_FILT_LSB +: 2]);
        o_ctrl.current_data_routing_en = data_control[BIT_CURRENT_ROUTING];
        o_ctrl.current_data_freeze     = data_control[BIT_CURRENT_FREEZE];
        o_ctrl.battery_temp_override   = data_control[BIT_BATT_TEMP_OVERRIDE];
        o_ctrl.monitor_data_freeze     = data_control[BIT_MONITOR_FREEZE];
    end

endmodule

// ===== core/diag_sync.sv
// Purpose: two-flop synchroniser for a vector of independent levels
// Assumes: each bit is a slow level; no bus coherency between bits
// Notes:   first stage feeds the second stage only
`timescale 1ns/1ps
module diag_sync
    import diag_pkg::*;
#(
    parameter int unsigned WIDTH = RAW_EVENT_W
)
(
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_nrst,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    // ==========================================================
    // per-bit synchroniser
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_bit
            logic [SYNC_STAGES-1:0] stage;
            logic [SYNC_STAGES-1:0] next_stage;

            always_comb
            begin
                next_stage = {stage[SYNC_STAGES-2:0], i_async[g]};
            end

            always_ff @(posedge i_ref_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    stage <= '0;
                else
                    stage <= next_stage;
            end

            assign o_sync[g] = stage[SYNC_STAGES-1];
        end
    endgenerate

endmodule
